// [common/msp_pkg.sv]
// Constants for the motion sequence parameter bank
// Function
// R01: Zero minimum time: active output just follows
// R02: Nonzero: stretch active output to minimum ms
// R03: Mode bit selects level or pulse output
// R04: Pulse outputs drop after pulse length ms
// R05: Read-only phase word, six phase flags
// R06: Read-only signed captured torque-sequence position
// R07: Read-only capability bitmap of sequence types
// R08: Read-only sequence capacity, numbers below it
// R09: Pointer selects record target, resets zero
// R10: Record has 26 sub-entries for selection; code decodes only sub-entries 1..5
// R11: Type codes 0..6, unsupported codes refused
// R12: Successor ranges -1..127, -1 means none
// R13: Master checks capability before writing type
// R14: Repeat counter decrements on each completion; code decrements only a nonzero counter
// R15: Nonzero counter branches to link target
// R16: Active output is bit 1 of dedicated word
// R17: Writes to read-only objects are refused
// R18: Out-of-range pointer writes are refused
package msp_pkg;
   // ***************************************
   // Object indexes and sub-indexes
   // ***************************************
   localparam logic [15:0] IDX_MIN_ACT  = 16'h3603;
   localparam logic [15:0] IDX_PULSE    = 16'h3604;
   localparam logic [15:0] IDX_PHASE    = 16'h3605;
   localparam logic [15:0] IDX_CAPPOS   = 16'h360b;
   localparam logic [15:0] IDX_CAPMAP   = 16'h360f;
   localparam logic [15:0] IDX_SELPTR   = 16'h3610;
   localparam logic [15:0] IDX_RECORD   = 16'h3611;
   localparam logic [15:0] IDX_CAPACITY = 16'h3612;
   localparam logic [7:0]  SUB_VAR      = 8'h00;
   localparam logic [7:0]  SUB_MODE     = 8'h01;
   localparam logic [7:0]  SUB_LEN      = 8'h02;
   localparam logic [7:0]  SUB_TYPE     = 8'h01;
   localparam logic [7:0]  SUB_SUCC     = 8'h02;
   localparam logic [7:0]  SUB_REPEAT   = 8'h03;
   localparam logic [7:0]  SUB_BRANCH   = 8'h04;
   localparam logic [7:0]  SUB_OUTEV    = 8'h05;
   localparam logic [15:0] PULSE_ELEMS  = 16'h0002;
   localparam logic [15:0] RECORD_ELEMS = 16'h001a;
   // ***************************************
   // Fields, codes and reset values
   // ***************************************
   localparam int          PHASE_W      = 6;
   localparam logic [15:0] CAP_MAP      = 16'h001f;
   localparam logic [15:0] SEQ_CAPACITY = 16'h0080;
   localparam int          SEQ_AW       = 7;
   localparam logic [15:0] TYPE_UNDEF   = 16'h0000;
   localparam logic [15:0] TYPE_CAM     = 16'h0006;
   localparam logic [15:0] SUCC_NONE    = 16'hffff;
   localparam logic [15:0] SUCC_MAX     = 16'h007f;
   localparam int          DED_SEQ_BIT  = 1;
   localparam logic [15:0] MIN_ACT_RST  = 16'h0000;
   localparam logic [15:0] PMODE_RST    = 16'h0000;
   localparam logic [15:0] PLEN_RST     = 16'h0000;
   localparam logic [15:0] SELPTR_RST   = 16'h0000;
   localparam logic [15:0] REC_ZERO_RST = 16'h0000;
   // ***************************************
   // Timing
   // ***************************************
   localparam int          MS_TIME_NS    = 1000000;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
endpackage

// [common/msp_tmr_if.sv]
// Millisecond timer link between bank and timer
`timescale 1ns/10ps
interface msp_tmr_if;
   logic        tick;
   logic        load;
   logic [15:0] len;
   logic        busy;
   modport ctrl (output tick, output load, output len, input busy);
   modport tmr  (input tick, input load, input len, output busy);
endinterface

// [hdl/msp_ms_timer.sv]
// Millisecond down-counter timer
`timescale 1ns/10ps
module msp_ms_timer
   import msp_pkg::*;
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Timer link
   msp_tmr_if.tmr    tif
);
   logic [16:0] cnt_q;
   logic [16:0] cnt_d;

   // One extra tick covers the partial first millisecond
   assign cnt_d = tif.load ? {1'b0, tif.len} + 17'h00001 :
                  (tif.tick && cnt_q != 17'h00000) ? cnt_q - 17'h00001 : cnt_q;
   assign tif.busy = cnt_q != 17'h00000;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         cnt_q <= 17'h00000;
      else
         cnt_q <= cnt_d;
   end
endmodule // msp_ms_timer

// [hdl/msp_bank.sv]
// Motion sequence parameter and status object bank
`timescale 1ns/10ps
module msp_bank
   import msp_pkg::*;
#(
   parameter int MS_CYCLES_P = MS_CYCLES
)
(
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               rst,
   // Object access
   input  wire logic               objReq,
   input  wire logic               objWrite,
   input  wire logic [15:0]        objIndex,
   input  wire logic [7:0]         objSub,
   input  wire logic [31:0]        objWrData,
   output logic                    objAck,
   output logic                    objAbort,
   output logic [31:0]             objRdData,
   // Sequencer status
   input  wire logic               seqRunning,
   input  wire logic               seqDone,
   input  wire logic [SEQ_AW-1:0]  seqDoneNum,
   input  wire logic [PHASE_W-1:0] phaseIn,
   input  wire logic               capStrobe,
   input  wire logic [31:0]        capPos,
   input  wire logic [15:0]        outSetReq,
   input  wire logic [15:0]        outClrReq,
   // Drive outputs
   output logic [15:0]             dedOut,
   output logic [15:0]             progOut,
   output logic                    branchValid,
   output logic [15:0]             branchTo
);
   // ***************************************
   // Storage
   // ***************************************
   logic [15:0]        minAct_q;
   logic [15:0]        pulseMode_q;
   logic [15:0]        pulseLen_q;
   logic [15:0]        selPtr_q;
   logic [PHASE_W-1:0] phase_q;
   logic signed [31:0] capPos_q;
   logic               seqRun_q;
   logic [31:0]        tickCnt_q;
   logic               msTick_q;
   logic               objAck_q;
   logic               objAbort_q;
   logic [31:0]        objRdData_q;
   logic [15:0]        dedOut_q;
   logic [15:0]        progOut_q;
   logic [15:0]        progOut_d;
   logic               branchValid_q;
   logic [15:0]        branchTo_q;
   logic [15:0]        typeMem   [SEQ_CAPACITY];
   logic [15:0]        succMem   [SEQ_CAPACITY];
   logic [15:0]        repMem    [SEQ_CAPACITY];
   logic [15:0]        branchMem [SEQ_CAPACITY];
   logic [15:0]        outEvMem  [SEQ_CAPACITY];

   function automatic logic inSeqRange(input logic [15:0] v);
      return (v == SUCC_NONE) || (v <= SUCC_MAX);
   endfunction

   // ***************************************
   // Object decode
   // ***************************************
   wire               isVar      = objSub == SUB_VAR;
   wire               hitMin     = objIndex == IDX_MIN_ACT && isVar;
   wire               hitPulseN  = objIndex == IDX_PULSE && isVar;
   wire               hitMode    = objIndex == IDX_PULSE && objSub == SUB_MODE;
   wire               hitLen     = objIndex == IDX_PULSE && objSub == SUB_LEN;
   wire               hitPhase   = objIndex == IDX_PHASE && isVar;
   wire               hitCapPos  = objIndex == IDX_CAPPOS && isVar;
   wire               hitCapMap  = objIndex == IDX_CAPMAP && isVar;
   wire               hitCapac   = objIndex == IDX_CAPACITY && isVar;
   wire               hitPtr     = objIndex == IDX_SELPTR && isVar;
   wire               hitRecN    = objIndex == IDX_RECORD && isVar;
   wire               hitRec     = objIndex == IDX_RECORD && !isVar && objSub <= SUB_OUTEV;
   wire               roHit      = hitPhase | hitCapPos | hitCapMap | hitCapac | hitPulseN | hitRecN;
   wire               anyHit     = roHit | hitMin | hitMode | hitLen | hitPtr | hitRec;
   wire [15:0]        wrVal      = objWrData[15:0];
   wire [2:0]         typeBit    = wrVal[2:0] - 3'h1;
   wire               typeOk     = wrVal == TYPE_UNDEF || (wrVal <= TYPE_CAM && CAP_MAP[typeBit]);
   wire               linkOk     = inSeqRange(wrVal);
   wire               ptrOk      = wrVal < SEQ_CAPACITY;
   wire               recBad     = (objSub == SUB_TYPE && !typeOk) ||
                                    ((objSub == SUB_SUCC || objSub == SUB_BRANCH) && !linkOk);
   wire               wrReject   = !anyHit | roHit | (hitPtr & !ptrOk) | (hitRec & recBad); // see R17 R18 R11 R12
   wire               doWr       = objReq & objWrite & !wrReject;
   wire               reject     = objWrite ? wrReject : !anyHit;
   wire [SEQ_AW-1:0]  selIdx     = selPtr_q[SEQ_AW-1:0];
   wire               wrRec      = doWr & hitRec; // see R09 R10
   wire [15:0]        recRd      = objSub == SUB_TYPE   ? typeMem[selIdx] :
                                   objSub == SUB_SUCC   ? succMem[selIdx] :
                                   objSub == SUB_REPEAT ? repMem[selIdx] :
                                   objSub == SUB_BRANCH ? branchMem[selIdx] : outEvMem[selIdx];
   wire [31:0]        rdMux      = hitMin    ? {16'h0000, minAct_q} :
                                   hitPulseN ? {16'h0000, PULSE_ELEMS} :
                                   hitMode   ? {16'h0000, pulseMode_q} :
                                   hitLen    ? {16'h0000, pulseLen_q} :
                                   hitPhase  ? {{(32-PHASE_W){1'b0}}, phase_q} : // see R05
                                   hitCapPos ? capPos_q : // see R06
                                   hitCapMap ? {16'h0000, CAP_MAP} : // see R07
                                   hitCapac  ? {16'h0000, SEQ_CAPACITY} : // see R08
                                   hitPtr    ? {16'h0000, selPtr_q} :
                                   hitRecN   ? {16'h0000, RECORD_ELEMS} :
                                   hitRec    ? {16'h0000, recRd} : 32'h00000000;

   // ***************************************
   // Object answer
   // ***************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         objAck_q    <= 1'b0;
         objAbort_q  <= 1'b0;
         objRdData_q <= 32'h00000000;
      end
      else
      begin
         objAck_q    <= objReq;
         objAbort_q  <= objReq & reject;
         objRdData_q <= (objReq && !objWrite) ? rdMux : objRdData_q;
      end
   end

   // ***************************************
   // Writable configuration
   // ***************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         minAct_q    <= MIN_ACT_RST;
         pulseMode_q <= PMODE_RST;
         pulseLen_q  <= PLEN_RST;
         selPtr_q    <= SELPTR_RST; // see R09
      end
      else
      begin
         minAct_q    <= (doWr && hitMin) ? wrVal : minAct_q;
         pulseMode_q <= (doWr && hitMode) ? wrVal : pulseMode_q; // see R03
         pulseLen_q  <= (doWr && hitLen) ? wrVal : pulseLen_q;
         selPtr_q    <= (doWr && hitPtr) ? wrVal : selPtr_q; // see R18
      end
   end

   // ***************************************
   // Status capture
   // ***************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         phase_q  <= '0;
         capPos_q <= 32'sh00000000;
      end
      else
      begin
         phase_q  <= phaseIn; // see R05
         capPos_q <= capStrobe ? capPos : capPos_q; // see R06
      end
   end

   // ***************************************
   // Sequence records
   // ***************************************
   wire [15:0] doneCnt  = repMem[seqDoneNum];
   wire        doneLoop = seqDone && doneCnt != 16'h0000;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < SEQ_CAPACITY; i++)
         begin
            typeMem[i]   <= TYPE_UNDEF;
            succMem[i]   <= SUCC_NONE;
            repMem[i]    <= REC_ZERO_RST;
            branchMem[i] <= SUCC_NONE;
            outEvMem[i]  <= REC_ZERO_RST;
         end
      end
      else
      begin
         if (wrRec && objSub == SUB_TYPE)
            typeMem[selIdx] <= wrVal; // see R11
         if (wrRec && objSub == SUB_SUCC)
            succMem[selIdx] <= wrVal; // see R12
         if (wrRec && objSub == SUB_REPEAT)
            repMem[selIdx] <= wrVal;
         if (wrRec && objSub == SUB_BRANCH)
            branchMem[selIdx] <= wrVal;
         if (wrRec && objSub == SUB_OUTEV)
            outEvMem[selIdx] <= wrVal;
         if (doneLoop)
            repMem[seqDoneNum] <= doneCnt - 16'h0001; // see R14
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         branchValid_q <= 1'b0;
         branchTo_q    <= SUCC_NONE;
      end
      else
      begin
         branchValid_q <= seqDone;
         branchTo_q    <= !seqDone ? branchTo_q :
                          doneLoop ? branchMem[seqDoneNum] : succMem[seqDoneNum]; // see R15
      end
   end

   // ***************************************
   // Millisecond tick
   // ***************************************
   wire tickWrap = tickCnt_q == 32'(MS_CYCLES_P - 1);

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         tickCnt_q <= 32'h00000000;
         msTick_q  <= 1'b0;
      end
      else
      begin
         tickCnt_q <= tickWrap ? 32'h00000000 : tickCnt_q + 32'h00000001;
         msTick_q  <= tickWrap;
      end
   end

   // ***************************************
   // Sequence active stretch
   // ***************************************
   msp_tmr_if seqIf ();
   assign seqIf.tick = msTick_q;
   assign seqIf.load = seqRunning && !seqRun_q && minAct_q != 16'h0000; // see R02
   assign seqIf.len  = minAct_q;

   msp_ms_timer u_seqTmr (
      .mclk (mclk),
      .rst  (rst),
      .tif  (seqIf)
   );

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         seqRun_q <= 1'b0;
         dedOut_q <= 16'h0000;
      end
      else
      begin
         seqRun_q              <= seqRunning;
         dedOut_q[DED_SEQ_BIT] <= seqRunning | seqIf.busy; // see R01 R02 R16
      end
   end

   // ***************************************
   // Programmable outputs
   // ***************************************
   logic [15:0] pulseBusy;
   logic [15:0] pulseLoad;

   for (genvar g = 0; g < 16; g++)
   begin : g_pulse
      msp_tmr_if pIf ();
      assign pulseLoad[g] = outSetReq[g] & pulseMode_q[g];
      assign pIf.tick     = msTick_q;
      assign pIf.load     = pulseLoad[g];
      assign pIf.len      = pulseLen_q;
      assign pulseBusy[g] = pIf.busy;

      msp_ms_timer u_pulseTmr (
         .mclk (mclk),
         .rst  (rst),
         .tif  (pIf)
      );
   end

   // Set wins over clear for level bits
   assign progOut_d = (pulseMode_q & (pulseLoad | pulseBusy)) | // see R04
                      (~pulseMode_q & (outSetReq | (progOut_q & ~outClrReq))); // see R03

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         progOut_q <= 16'h0000;
      else
         progOut_q <= progOut_d;
   end

   assign objAck      = objAck_q;
   assign objAbort    = objAbort_q;
   assign objRdData   = objRdData_q;
   assign dedOut      = dedOut_q;
   assign progOut     = progOut_q;
   assign branchValid = branchValid_q;
   assign branchTo    = branchTo_q;

   // ***************************************
   // Assertions
   // ***************************************
   a_ro_write_abort: // see R17
   assert property (@(posedge mclk) disable iff (rst)
      objReq && objWrite && roHit |=> objAck && objAbort)
      else $error("Read-only write not refused");

   a_ptr_range_keep: // see R18
   assert property (@(posedge mclk) disable iff (rst)
      objReq && objWrite && hitPtr && !ptrOk |=> $stable(selPtr_q) && objAbort)
      else $error("Bad pointer write changed selection");

   a_type_reject: // see R11
   assert property (@(posedge mclk) disable iff (rst)
      objReq && objWrite && hitRec && objSub == SUB_TYPE && wrVal > TYPE_CAM |=> objAbort)
      else $error("Illegal type code accepted");

   a_seq_follow: // see R01
   assert property (@(posedge mclk) disable iff (rst)
      minAct_q == 16'h0000 && !seqIf.busy |=> dedOut[DED_SEQ_BIT] == $past(seqRunning))
      else $error("Active output not following sequence");

   a_seq_stretch: // see R02
   assert property (@(posedge mclk) disable iff (rst)
      seqRunning && !seqRun_q && minAct_q != 16'h0000 |=> dedOut[DED_SEQ_BIT] [*8])
      else $error("Active output not stretched");

   a_pulse_start: // see R04
   assert property (@(posedge mclk) disable iff (rst)
      outSetReq[0] && pulseMode_q[0] |=> progOut[0] ##1 progOut[0])
      else $error("Pulse output did not start");

   a_level_hold: // see R03
   assert property (@(posedge mclk) disable iff (rst)
      !pulseMode_q[0] && progOut[0] && !outClrReq[0] && !$changed(pulseMode_q) |=> progOut[0])
      else $error("Level output dropped on its own");

   a_phase_read: // see R05
   assert property (@(posedge mclk) disable iff (rst)
      objReq && !objWrite && hitPhase |=> objRdData == {{(32-PHASE_W){1'b0}}, $past(phase_q)})
      else $error("Phase word read mismatch");

   a_branch_link: // see R15
   assert property (@(posedge mclk) disable iff (rst)
      doneLoop |=> branchValid && branchTo == $past(branchMem[seqDoneNum]))
      else $error("Branch did not take link target");

   a_count_dec: // see R14
   assert property (@(posedge mclk) disable iff (rst)
      doneLoop |=> repMem[$past(seqDoneNum)] == $past(doneCnt) - 16'h0001)
      else $error("Repeat counter not decremented");
endmodule // msp_bank

// [testbench/msp_master_model.sv]
// Object bus master model for the parameter bank
`timescale 1ns/10ps
module msp_master_model
   import msp_pkg::*;
(
   // Clock
   input  wire logic        mclk,
   // Object access
   output logic             objReq,
   output logic             objWrite,
   output logic [15:0]      objIndex,
   output logic [7:0]       objSub,
   output logic [31:0]      objWrData,
   input  wire logic        objAck,
   input  wire logic        objAbort,
   input  wire logic [31:0] objRdData
);
   initial
   begin
      objReq    = 1'b0;
      objWrite  = 1'b0;
      objIndex  = 16'h0000;
      objSub    = 8'h00;
      objWrData = 32'h0000_0000;
   end
   // One request, answer taken one cycle later
   task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                         input logic [31:0] wd, output logic [31:0] rd, output logic ab);
      @(negedge mclk);
      objReq    = 1'b1;
      objWrite  = wr;
      objIndex  = idx;
      objSub    = sub;
      objWrData = wd;
      @(negedge mclk);
      rd        = objRdData;
      ab        = (objAck === 1'b1) ? objAbort : 1'bx;
      objReq    = 1'b0;
      // Released lines do not keep their value
      objIndex  = ~objIndex;
      objSub    = ~objSub;
      objWrData = ~objWrData;
   endtask
   // Type write only after a capability check
   task automatic set_type(input logic [15:0] code, output logic ab);
      logic [31:0] cap;
      logic        cab;
      access(1'b0, IDX_CAPMAP, SUB_VAR, 32'h0000_0000, cap, cab);
      if (code != 16'h0000 && cap[code - 16'h0001] !== 1'b1)
         ab = 1'b1;
      else
         access(1'b1, IDX_RECORD, SUB_TYPE, {16'h0000, code}, cap, ab);
   endtask
endmodule // msp_master_model

// [testbench/testbench.sv]
// Self-checking testbench of the parameter bank
`timescale 1ns/10ps
module testbench
   import msp_pkg::*;
;
   localparam int MS = 10;
   logic mclk, rst, objReq, objWrite, objAck, objAbort;
   logic [15:0] objIndex, dedOut, progOut, branchTo, outSetReq, outClrReq;
   logic [7:0] objSub;
   logic [31:0] objWrData, objRdData, capPos;
   logic seqRunning, seqDone, capStrobe, branchValid;
   logic [SEQ_AW-1:0] seqDoneNum;
   logic [PHASE_W-1:0] phaseIn;
   int err_total, n_tests, cycles;
   // ***************************************
   // Design, partner, clock
   // ***************************************
   msp_bank #(.MS_CYCLES_P(MS)) i_dut (.mclk(mclk), .rst(rst), .objReq(objReq), .objWrite(objWrite),
      .objIndex(objIndex), .objSub(objSub), .objWrData(objWrData), .objAck(objAck), .objAbort(objAbort),
      .objRdData(objRdData), .seqRunning(seqRunning), .seqDone(seqDone), .seqDoneNum(seqDoneNum),
      .phaseIn(phaseIn), .capStrobe(capStrobe), .capPos(capPos), .outSetReq(outSetReq),
      .outClrReq(outClrReq), .dedOut(dedOut), .progOut(progOut), .branchValid(branchValid),
      .branchTo(branchTo));
   msp_master_model i_master (.mclk(mclk), .objReq(objReq), .objWrite(objWrite), .objIndex(objIndex),
      .objSub(objSub), .objWrData(objWrData), .objAck(objAck), .objAbort(objAbort), .objRdData(objRdData));
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         err_total++;
         results();
      end
   end
   // ***************************************
   // Shared tasks
   // ***************************************
   task automatic results();
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic ea);
      logic [31:0] r;
      logic        a;
      i_master.access(1'b1, idx, sub, d, r, a);
      chk({31'h0, a}, {31'h0, ea});
   endtask
   task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
      logic [31:0] r;
      logic        a;
      i_master.access(1'b0, idx, sub, 32'h0, r, a);
      chk({31'h0, a}, 32'h0);
      chk(r, e);
   endtask
   task automatic count_high(input logic useProg, input int len, output int n);
      n = 0;
      repeat (len)
      begin
         n += useProg ? int'(progOut[0] === 1'b1) : int'(dedOut[DED_SEQ_BIT] === 1'b1);
         @(negedge mclk);
      end
   endtask
   // ***************************************
   // Scenarios
   // ***************************************
   task automatic t_reset_ro();
      logic [31:0] r;
      logic        a;
      rd(IDX_CAPACITY, SUB_VAR, {16'h0, SEQ_CAPACITY});
      rd(IDX_CAPMAP, SUB_VAR, {16'h0, CAP_MAP});
      rd(IDX_SELPTR, SUB_VAR, 32'h0);
      rd(IDX_RECORD, SUB_VAR, 32'h1a);
      rd(IDX_PULSE, SUB_VAR, 32'h2);
      rd(IDX_MIN_ACT, SUB_VAR, 32'h0);
      rd(IDX_RECORD, SUB_SUCC, 32'hffff);
      i_master.access(1'b0, 16'h3606, SUB_VAR, 32'h0, r, a);
      chk({31'h0, a}, 32'h1);
      wr(IDX_CAPACITY, SUB_VAR, 32'h5, 1'b1);
      wr(IDX_PHASE, SUB_VAR, 32'h5, 1'b1);
      wr(IDX_CAPPOS, SUB_VAR, 32'h5, 1'b1);
      wr(IDX_CAPMAP, SUB_VAR, 32'h3f, 1'b1);
      rd(IDX_CAPACITY, SUB_VAR, {16'h0, SEQ_CAPACITY});
      rd(IDX_CAPMAP, SUB_VAR, {16'h0, CAP_MAP});
   endtask
   task automatic t_status();
      @(negedge mclk);
      phaseIn   = 6'h2a;
      capPos    = 32'h8000_0001;
      capStrobe = 1'b1;
      @(negedge mclk);
      capStrobe = 1'b0;
      capPos    = 32'h0000_1234;
      rd(IDX_PHASE, SUB_VAR, 32'h2a);
      rd(IDX_CAPPOS, SUB_VAR, 32'h8000_0001);
   endtask
   task automatic t_record();
      logic a;
      wr(IDX_SELPTR, SUB_VAR, 32'h80, 1'b1);
      wr(IDX_SELPTR, SUB_VAR, 32'hffff, 1'b1);
      wr(IDX_SELPTR, SUB_VAR, 32'h7f, 1'b0);
      rd(IDX_SELPTR, SUB_VAR, 32'h7f);
      for (int c = 0; c < 8; c++)
         wr(IDX_RECORD, SUB_TYPE, c, (c > 6) || (c > 0 && !CAP_MAP[c - 1]));
      rd(IDX_RECORD, SUB_TYPE, 32'h5);
      wr(IDX_RECORD, SUB_SUCC, 32'hffff, 1'b0);
      wr(IDX_RECORD, SUB_SUCC, 32'h7f, 1'b0);
      wr(IDX_RECORD, SUB_SUCC, 32'h80, 1'b1);
      wr(IDX_RECORD, SUB_SUCC, 32'hfffe, 1'b1);
      rd(IDX_RECORD, SUB_SUCC, 32'h7f);
      wr(IDX_SELPTR, SUB_VAR, 32'h0, 1'b0);
      rd(IDX_RECORD, SUB_TYPE, 32'h0);
      i_master.set_type(16'h0001, a);
      chk({31'h0, a}, 32'h0);
      rd(IDX_RECORD, SUB_TYPE, 32'h1);
   endtask
   task automatic t_branch();
      logic [15:0] exp [3];
      exp = '{16'h0005, 16'h0005, 16'h0009};
      wr(IDX_SELPTR, SUB_VAR, 32'h3, 1'b0);
      wr(IDX_RECORD, SUB_REPEAT, 32'h2, 1'b0);
      wr(IDX_RECORD, SUB_BRANCH, 32'h5, 1'b0);
      wr(IDX_RECORD, SUB_SUCC, 32'h9, 1'b0);
      wr(IDX_RECORD, SUB_BRANCH, 32'h80, 1'b1);
      wr(IDX_RECORD, SUB_OUTEV, 32'h1234, 1'b0);
      rd(IDX_RECORD, SUB_OUTEV, 32'h1234);
      for (int i = 0; i < 3; i++)
      begin
         @(negedge mclk);
         seqDone    = 1'b1;
         seqDoneNum = 7'h03;
         @(negedge mclk);
         seqDone    = 1'b0;
         chk({31'h0, branchValid}, 32'h1);
         chk({16'h0, branchTo}, {16'h0, exp[i]});
      end
      rd(IDX_RECORD, SUB_REPEAT, 32'h0);
      rd(IDX_RECORD, SUB_BRANCH, 32'h5);
   endtask
   task automatic t_active(input logic [15:0] minMs);
      int n;
      wr(IDX_MIN_ACT, SUB_VAR, {16'h0, minMs}, 1'b0);
      rd(IDX_MIN_ACT, SUB_VAR, {16'h0, minMs});
      @(negedge mclk);
      seqRunning = 1'b1;
      @(negedge mclk);
      seqRunning = 1'b0;
      chk({16'h0, dedOut}, 32'h2);
      count_high(1'b0, 50, n);
      if (minMs == 16'h0)
         chk(n, 1);
      else
         chk({31'h0, n >= minMs * MS && n <= (minMs + 1) * MS + 1}, 32'h1);
      chk({16'h0, dedOut}, 32'h0);
   endtask
   task automatic t_outputs();
      int n;
      wr(IDX_PULSE, SUB_MODE, 32'h1, 1'b0);
      wr(IDX_PULSE, SUB_LEN, 32'h3, 1'b0);
      @(negedge mclk);
      outSetReq = 16'h0003;
      @(negedge mclk);
      outSetReq = 16'h0000;
      outClrReq = 16'h0001;
      count_high(1'b1, 50, n);
      chk({31'h0, n >= 3 * MS && n <= 4 * MS + 1}, 32'h1);
      chk({31'h0, progOut[1]}, 32'h1);
      outClrReq = 16'h0002;
      @(negedge mclk);
      outClrReq = 16'h0000;
      chk({16'h0, progOut}, 32'h0);
      wr(IDX_PULSE, SUB_MODE, 32'h0, 1'b0);
      rd(IDX_PULSE, SUB_LEN, 32'h3);
      @(negedge mclk);
      outSetReq = 16'h0001;
      @(negedge mclk);
      outSetReq = 16'h0000;
      repeat (2) @(negedge mclk);
      chk({16'h0, progOut}, 32'h1);
      outClrReq = 16'h0001;
      @(negedge mclk);
      outClrReq = 16'h0000;
      chk({16'h0, progOut}, 32'h0);
   endtask
   // ***************************************
   // Main sequence
   // ***************************************
   initial
   begin
      {rst, seqRunning, seqDone, capStrobe} = 4'hf;
      {seqRunning, seqDone, capStrobe} = 3'h0;
      seqDoneNum = 7'h00;
      phaseIn    = 6'h00;
      capPos     = 32'h0;
      outSetReq  = 16'h0;
      outClrReq  = 16'h0;
      err_total  = 0;
      n_tests    = 0;
      cycles     = 0;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      t_reset_ro();
      t_status();
      t_record();
      t_branch();
      t_active(16'h0000);
      t_active(16'h0002);
      t_outputs();
      results();
   end
endmodule // testbench
